// >>> hw/efs_fifo_service.sv
// Purpose: FIFO service logic for a parallel port in FIFO and extended modes
// Assumes: APB slave; pins synchronised here; peripheral byte engine outside
// Notes: Peripheral side is a valid/ready byte stream in both directions

`timescale 1ns/1ps

module efs_fifo_service
    import efs_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ISA DMA pins
    input wire logic port_dma_ack_n,
    input wire logic dma_tc,
    input wire logic io_read_n,
    input wire logic [7:0] dma_wdata,
    output logic [7:0] dma_rdata,
    output logic port_dma_request,
    // Shared interrupt line, open drain
    output logic port_irq_out,
    output logic port_irq_oe,
    // Peripheral status pins
    input wire logic peripheral_fault_n,
    input wire logic peripheral_ack_n,
    // Control pin drive
    input wire efs_ctl_pins_t ctl_level,
    output efs_ctl_pins_t ctl_out,
    output efs_ctl_pins_t ctl_oe,
    // Forward stream to peripheral engine, bit 8 marks a command
    output logic [8:0] fwd_data,
    output logic fwd_valid,
    input wire logic fwd_ready,
    // Reverse stream from peripheral engine
    input wire logic [8:0] rev_data,
    input wire logic rev_valid,
    output logic rev_ready
);
    ////////////////////////////////////////////////////////////////////////
    efs_ctrl_t ctrl_r;
    logic [4:0] count_r;
    logic [3:0] wptr_r, rptr_r;
    logic [2:0] ack_s_r, flt_s_r, ior_s_r, tc_s_r;
    logic svc_prev_r, flt_en_prev_r;
    logic [7:0] rle_left_r;
    logic rle_hold_r;
    logic [5:0] burst_r;
    logic [7:0] rearm_r;
    logic tc_stop_r;
    logic [2:0] pulse_r;
    logic [8:0] rd_q;
    logic rd_valid_r;

    function automatic logic fifo_mode(input logic [2:0] m);
        fifo_mode = (m == EFS_MODE_FIFO) || (m == EFS_MODE_ECP) || (m == EFS_MODE_TEST);
    endfunction : fifo_mode

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: stage 0 is read only by stage 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_s_r <= 3'h7;
            flt_s_r <= 3'h7;
            ior_s_r <= 3'h7;
            tc_s_r <= 3'h0;
        end else begin
            ack_s_r <= {ack_s_r[1:0], port_dma_ack_n};
            flt_s_r <= {flt_s_r[1:0], peripheral_fault_n};
            ior_s_r <= {ior_s_r[1:0], io_read_n};
            tc_s_r <= {tc_s_r[1:0], dma_tc};
        end
    end

    // Peripheral ack goes through its own three-stage chain
    logic [2:0] pack_s_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pack_s_r <= 3'h7;
        end else begin
            pack_s_r <= {pack_s_r[1:0], peripheral_ack_n};
        end
    end

    logic dack, dack_fall, ior_fall, tc_hit;
    assign dack = !ack_s_r[1];
    assign dack_fall = ack_s_r[2] && !ack_s_r[1];
    assign ior_fall = ior_s_r[2] && !ior_s_r[1];
    assign tc_hit = tc_s_r[1] && !tc_s_r[2] && dack;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic acc, wr, rd;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign pready = 1'b1;

    logic fifo_on, fwd_dir;
    assign fifo_on = fifo_mode(ctrl_r.mode);
    assign fwd_dir = !ctrl_r.dir;

    logic full, empty;
    assign full = (count_r == EFS_DEPTH_C);
    assign empty = (count_r == 5'h00);

    logic dma_active;
    assign dma_active = ctrl_r.dma_request_enable && !ctrl_r.service_disable;

    // DMA cycle strobe: acknowledge alone selects the FIFO
    logic dma_cyc;
    assign dma_cyc = dack_fall && dma_active && fifo_on;

    // Host push: APB to data/command port or a DMA write cycle
    logic push_host, pop_host;
    logic [8:0] push_word;
    assign push_host = fifo_on && fwd_dir && !full &&
        ((wr && (paddr == EFS_DATA_OFS || paddr == EFS_CMD_OFS)) || dma_cyc);
    assign push_word = dma_cyc ? {1'b0, dma_wdata} :
        {paddr == EFS_CMD_OFS, pwdata[7:0]};
    assign pop_host = fifo_on && !fwd_dir && !empty &&
        ((rd && paddr == EFS_DATA_OFS) || dma_cyc);

    // Reverse stream: command byte with bit 7 clear sets a repeat, data byte is expanded
    logic rev_take, rev_push;
    assign rev_ready = fifo_on && !fwd_dir && !full && !rle_hold_r;
    assign rev_take = rev_valid && rev_ready;
    assign rev_push = (rev_take && !rev_data[8]) || (rle_hold_r && !full);

    logic rle_load;
    assign rle_load = rev_take && rev_data[8] && !rev_data[7];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rle_left_r <= 8'h00;
            rle_hold_r <= 1'b0;
        end else if (!fifo_on) begin
            rle_left_r <= 8'h00;
            rle_hold_r <= 1'b0;
        end else if (rle_load) begin
            rle_left_r <= {1'b0, rev_data[6:0]};
        end else if (rev_take && !rev_data[8] && rle_left_r != 8'h00) begin
            rle_hold_r <= 1'b1;
        end else if (rle_hold_r && !full) begin
            rle_left_r <= rle_left_r - 8'h01;
            rle_hold_r <= (rle_left_r != 8'h01);
        end
    end

    logic [8:0] rev_byte_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rev_byte_r <= 9'h000;
        end else if (rev_take && !rev_data[8]) begin
            rev_byte_r <= rev_data;
        end
    end

    // Forward stream drains to the peripheral engine
    logic fwd_pop;
    assign fwd_pop = fifo_on && fwd_dir && rd_valid_r && fwd_ready && ctrl_r.mode != EFS_MODE_TEST;

    logic push, pop;
    logic [8:0] wdat;
    assign push = push_host || rev_push;
    assign wdat = rev_push ? (rle_hold_r ? rev_byte_r : rev_data) : push_word;
    assign pop = pop_host || fwd_pop;

    ////////////////////////////////////////////////////////////////////////
    // FIFO pointers; registered read data holds the head word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_r <= 4'h0;
            rptr_r <= 4'h0;
            count_r <= 5'h00;
        end else if (!fifo_on) begin
            wptr_r <= 4'h0;
            rptr_r <= 4'h0;
            count_r <= 5'h00;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 4'h1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 4'h1;
            end
            count_r <= count_r + {4'h0, push} - {4'h0, pop};
        end
    end

    // Head word valid one cycle after pointer settles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= !empty && !pop && !(push && count_r == 5'h00);
        end
    end

    efs_mem u_mem (
        .pclk(pclk),
        .we(push),
        .waddr(wptr_r),
        .wdata(wdat),
        .raddr(rptr_r),
        .rdata(rd_q)
    );

    assign fwd_data = rd_q;
    assign fwd_valid = fifo_on && fwd_dir && rd_valid_r && ctrl_r.mode != EFS_MODE_TEST;
    assign dma_rdata = rd_q[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Threshold arithmetic
    logic [4:0] thr_eff, trigger;
    assign thr_eff = ({1'b0, ctrl_r.thr} == EFS_THR_CAP) ? EFS_THR_CAP :
        {1'b0, ctrl_r.thr} + 5'h01;
    assign trigger = EFS_DEPTH_C - thr_eff;

    logic svc_cond;
    always_comb begin
        svc_cond = 1'b0;
        if (fifo_on && !ctrl_r.dma_request_enable) begin
            if (fwd_dir) begin
                svc_cond = (EFS_DEPTH_C - count_r) >= trigger;
            end else begin
                svc_cond = count_r >= trigger;
            end
        end
    end

    logic svc_prev_cond_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_prev_r <= 1'b1;
            svc_prev_cond_r <= 1'b0;
            flt_en_prev_r <= 1'b1;
        end else begin
            svc_prev_r <= ctrl_r.service_disable;
            svc_prev_cond_r <= svc_cond;
            flt_en_prev_r <= ctrl_r.fault_irq_enable_n;
        end
    end

    // Service event: rising condition, or enable found it already true
    logic svc_evt, tc_evt, flt_evt, ack_evt, irq_evt;
    assign svc_evt = !ctrl_r.service_disable && svc_cond &&
        (!svc_prev_cond_r || svc_prev_r);
    assign tc_evt = tc_hit && dma_active;
    assign flt_evt = !ctrl_r.fault_irq_enable_n &&
        ((flt_s_r[2] && !flt_s_r[1]) || (flt_en_prev_r && !flt_s_r[1]));
    assign ack_evt = ctrl_r.ack_irq_enable && !pack_s_r[2] && pack_s_r[1];
    assign irq_evt = svc_evt || tc_evt || flt_evt || ack_evt;

    // Short low pulse, then release so the line can be shared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_r <= 3'h0;
        end else if (irq_evt) begin
            pulse_r <= EFS_IRQ_PULSE;
        end else if (pulse_r != 3'h0) begin
            pulse_r <= pulse_r - 3'h1;
        end
    end
    assign port_irq_out = 1'b0;
    assign port_irq_oe = (pulse_r != 3'h0);

    ////////////////////////////////////////////////////////////////////////
    // Control register; terminal count wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '{thr: EFS_THR_RST, ack_irq_enable: 1'b0, fault_irq_enable_n: 1'b1,
                dma_request_enable: 1'b0, service_disable: 1'b1, dir: 1'b0, mode: EFS_MODE_RST};
        end else begin
            if (wr && paddr == EFS_CTRL_OFS) begin
                ctrl_r.mode <= pwdata[EFS_MODE_LSB +: 3];
                ctrl_r.dir <= pwdata[EFS_DIR_BIT];
                ctrl_r.service_disable <= pwdata[EFS_SVC_BIT];
                ctrl_r.dma_request_enable <= pwdata[EFS_DMA_BIT];
                ctrl_r.fault_irq_enable_n <= pwdata[EFS_FLT_BIT];
                ctrl_r.ack_irq_enable <= pwdata[EFS_ACK_BIT];
                ctrl_r.thr <= pwdata[EFS_THR_LSB +: 4];
            end
            if (tc_evt) begin
                ctrl_r.service_disable <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DMA request: burst limit and re-arm after acknowledge idles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_r <= 6'h00;
            rearm_r <= 8'h00;
        end else if (burst_r == EFS_BURST_MAX) begin
            if (dack) begin
                rearm_r <= 8'h00;
            end else if (rearm_r == EFS_REARM_CYC) begin
                burst_r <= 6'h00;
                rearm_r <= 8'h00;
            end else begin
                rearm_r <= rearm_r + 8'h01;
            end
        end else if (dma_cyc) begin
            burst_r <= burst_r + 6'h01;
        end else if (!port_dma_request) begin
            burst_r <= 6'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_stop_r <= 1'b0;
        end else if (tc_hit) begin
            tc_stop_r <= 1'b1;
        end else if (!ctrl_r.service_disable) begin
            tc_stop_r <= 1'b0;
        end
    end

    // Last byte: drop on acknowledge, or on read strobe if none seen
    logic last_byte;
    assign last_byte = !fwd_dir ? (count_r == 5'h01) : (count_r == 5'h0F);

    logic want;
    assign want = fwd_dir ? !full : !empty;
    assign port_dma_request = dma_active && fifo_on && want && !tc_stop_r && !tc_hit &&
        (burst_r != EFS_BURST_MAX) && !(last_byte && (dack || ior_fall));

    ////////////////////////////////////////////////////////////////////////
    // Control pin drivers: open-collector only in standard mode
    always_comb begin
        ctl_out = ctl_level;
        if (ctrl_r.mode == EFS_MODE_STD) begin
            ctl_out = '0;
            ctl_oe = ~ctl_level;
        end else begin
            ctl_oe = '1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                EFS_CTRL_OFS: prdata <= {20'h00000, ctrl_r};
                EFS_STAT_OFS: prdata <= {24'h000000, svc_cond, port_dma_request, full, empty, count_r[3:0]};
                EFS_PERI_OFS: prdata <= {30'h00000000, pack_s_r[1], flt_s_r[1]};
                EFS_DATA_OFS: prdata <= {23'h000000, rd_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    assign pslverr = acc && !(paddr == EFS_DATA_OFS || paddr == EFS_CMD_OFS || paddr == EFS_CTRL_OFS ||
        paddr == EFS_STAT_OFS || paddr == EFS_PERI_OFS);
endmodule : efs_fifo_service

// >>> include/efs_pkg.sv
// Purpose: Shared constants and types for the parallel port FIFO service block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Byte addresses of the control registers are local offsets

package efs_pkg;

    // Register byte offsets
    localparam logic [11:0] EFS_DATA_OFS = 12'h400;
    localparam logic [11:0] EFS_CMD_OFS = 12'h000;
    localparam logic [11:0] EFS_CTRL_OFS = 12'h004;
    localparam logic [11:0] EFS_STAT_OFS = 12'h008;
    localparam logic [11:0] EFS_PERI_OFS = 12'h00C;

    // Control field positions
    localparam int EFS_MODE_LSB = 0;
    localparam int EFS_DIR_BIT = 3;
    localparam int EFS_SVC_BIT = 4;
    localparam int EFS_DMA_BIT = 5;
    localparam int EFS_FLT_BIT = 6;
    localparam int EFS_ACK_BIT = 7;
    localparam int EFS_THR_LSB = 8;

    // Reset values
    localparam logic [2:0] EFS_MODE_RST = 3'h0;
    localparam logic [3:0] EFS_THR_RST = 4'h0;

    // Modes
    localparam logic [2:0] EFS_MODE_STD = 3'h0;
    localparam logic [2:0] EFS_MODE_BIDIR = 3'h1;
    localparam logic [2:0] EFS_MODE_FIFO = 3'h2;
    localparam logic [2:0] EFS_MODE_ECP = 3'h3;
    localparam logic [2:0] EFS_MODE_TEST = 3'h6;

    // FIFO geometry
    localparam int EFS_DEPTH = 16;
    localparam logic [4:0] EFS_DEPTH_C = 5'h10;
    localparam logic [4:0] EFS_THR_CAP = 5'h0F;

    // DMA burst limit and re-arm time
    localparam logic [5:0] EFS_BURST_MAX = 6'h20;
    localparam int EFS_CLK_PS = 4000;
    localparam int EFS_REARM_NS = 350;
    localparam int EFS_REARM_CYC_I = (EFS_REARM_NS * 1000 + EFS_CLK_PS - 1) / EFS_CLK_PS;
    localparam logic [7:0] EFS_REARM_CYC = 8'(EFS_REARM_CYC_I);

    // Interrupt pulse length
    localparam logic [2:0] EFS_IRQ_PULSE = 3'h4;

    typedef struct packed {
        logic [3:0] thr;
        logic ack_irq_enable;
        logic fault_irq_enable_n;
        logic dma_request_enable;
        logic service_disable;
        logic dir;
        logic [2:0] mode;
    } efs_ctrl_t;

    typedef struct packed {
        logic host_strobe_n;
        logic host_feed_n;
        logic host_init_n;
        logic host_select_n;
    } efs_ctl_pins_t;

endpackage : efs_pkg

// >>> hw/efs_mem.sv
// Purpose: 16 x 9 storage for the transfer FIFO, registered read data
// Assumes: One write and one read port on pclk
// Notes: Bit 8 marks a command byte

`timescale 1ns/1ps

module efs_mem (
    // Clock
    input wire logic pclk,
    // Write port
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [8:0] wdata,
    // Read port
    input wire logic [3:0] raddr,
    output logic [8:0] rdata
);
    logic [8:0] mem_r [0:15];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk) begin
        rdata <= mem_r[raddr];
    end
endmodule : efs_mem

// >>> sim/efs_assertions.sv
// Purpose: Port-level checks on the parallel port FIFO service block
// Assumes: Single pclk domain, presetn asynchronous active low
// Notes: Bound to efs_fifo_service; burst and re-arm counts use raw DMA pins

`timescale 1ns/1ps

module efs_assertions
    import efs_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // DMA pins
    input wire logic port_dma_ack_n,
    input wire logic dma_tc,
    input wire logic port_dma_request,
    // Interrupt
    input wire logic port_irq_out,
    input wire logic port_irq_oe,
    // Control pins
    input wire efs_ctl_pins_t ctl_level,
    input wire efs_ctl_pins_t ctl_out,
    input wire efs_ctl_pins_t ctl_oe
);
    logic mapped;
    logic ack_q;
    logic req_q;
    logic capped_r;
    logic [5:0] burst_r;
    logic [7:0] high_r;

    assign mapped = paddr inside {EFS_DATA_OFS, EFS_CMD_OFS, EFS_CTRL_OFS, EFS_STAT_OFS, EFS_PERI_OFS};

    ////////////////////////////////////////////////////////////////////////////
    // Raw pin counters: a synchroniser only delays, so raw counts bound the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q <= 1'b1;
            req_q <= 1'b0;
            burst_r <= 6'h00;
            capped_r <= 1'b0;
            high_r <= 8'h00;
        end else begin
            ack_q <= port_dma_ack_n;
            req_q <= port_dma_request;
            if (!port_dma_request) burst_r <= 6'h00;
            else if (ack_q && !port_dma_ack_n) burst_r <= burst_r + 6'h01;
            if (burst_r == EFS_BURST_MAX) capped_r <= 1'b1;
            else if (port_dma_request && !req_q) capped_r <= 1'b0;
            if (!port_dma_ack_n) high_r <= 8'h00;
            else if (high_r != 8'hFF) high_r <= high_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    drive_kind_a: assert property ((ctl_out == 4'h0 && ctl_oe == ~ctl_level) ||
        (ctl_out == ctl_level && ctl_oe == 4'hF)) else $error("control pin drive kind wrong");
    irq_low_a: assert property (port_irq_oe |-> !port_irq_out) else $error("irq driven high");
    irq_pulse_a: assert property ($rose(port_irq_oe) |-> port_irq_oe[*4] ##1 !port_irq_oe)
        else $error("irq pulse length wrong");
    bad_addr_a: assert property (psel && penable && !mapped |-> pslverr) else $error("no slave error");
    good_addr_a: assert property (psel && penable && mapped |-> pready && !pslverr)
        else $error("mapped access refused");
    burst_cap_a: assert property (burst_r <= EFS_BURST_MAX) else $error("dma burst too long");
    rearm_wait_a: assert property ($rose(port_dma_request) && capped_r |-> high_r >= EFS_REARM_CYC)
        else $error("dma request re-armed early");
    tc_drop_a: assert property ($fell(port_dma_ack_n) && dma_tc |-> ##[1:8] !port_dma_request)
        else $error("request held after count");
    tc_irq_a: assert property ($fell(port_dma_ack_n) && dma_tc |-> ##[1:8] port_irq_oe)
        else $error("no irq on terminal count");

    irq_seen_c: cover property ($rose(port_irq_oe));
    rearm_seen_c: cover property (capped_r && $rose(port_dma_request));
    slverr_seen_c: cover property (psel && penable && pslverr);
endmodule : efs_assertions

bind efs_fifo_service efs_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .port_dma_ack_n(port_dma_ack_n), .dma_tc(dma_tc),
    .port_dma_request(port_dma_request), .port_irq_out(port_irq_out), .port_irq_oe(port_irq_oe),
    .ctl_level(ctl_level), .ctl_out(ctl_out), .ctl_oe(ctl_oe));

// >>> sim/efs_dma_model.sv
// Purpose: Host DMA controller answering the port's DMA request
// Assumes: Bench sets the direction and the running byte total
// Notes: Ack held 5 cycles, released 3; written bytes are the running count

`timescale 1ns/1ps

module efs_dma_model
    import efs_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Job
    input wire logic to_dev,
    input wire logic [7:0] total,
    output logic [7:0] done,
    // ISA DMA pins
    input wire logic port_dma_request,
    input wire logic [7:0] dma_rdata,
    output logic port_dma_ack_n,
    output logic dma_tc,
    output logic io_read_n,
    output logic [7:0] dma_wdata
);
    logic [7:0] rd_mem [0:63];

    initial begin
        port_dma_ack_n = 1'b1;
        dma_tc = 1'b0;
        io_read_n = 1'b1;
        dma_wdata = 8'hFF;
        done = 8'h00;
        forever begin
            @(posedge pclk);
            if (port_dma_request === 1'b1 && done < total) begin
                port_dma_ack_n <= 1'b0;
                io_read_n <= to_dev;
                dma_tc <= (done + 8'h01 == total);
                dma_wdata <= done;
                @(posedge pclk);
                rd_mem[done[5:0]] = dma_rdata;
                repeat (4) @(posedge pclk);
                port_dma_ack_n <= 1'b1;
                io_read_n <= 1'b1;
                dma_tc <= 1'b0;
                dma_wdata <= ~done;
                done <= done + 8'h01;
                repeat (2) @(posedge pclk);
            end
        end
    end
endmodule : efs_dma_model

// >>> sim/efs_fifo_service_test.sv
// Purpose: Self-checking bench for the parallel port FIFO service block
// Assumes: Zero-wait APB slave; bench plays peripheral engine and pins
// Notes: Mode changes pass through mode 001 with service disabled

`timescale 1ns/1ps

module efs_fifo_service_test
    import efs_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, port_dma_ack_n, dma_tc, io_read_n, port_dma_request, port_irq_out, port_irq_oe;
    logic [7:0] dma_wdata, dma_rdata, dma_done, total = 8'h00;
    logic fault_n = 1'b1, ack_n = 1'b1, fwd_valid, fwd_ready = 1'b0, rev_valid = 1'b0, rev_ready;
    logic to_dev = 1'b0, irq_q = 1'b0;
    logic [8:0] fwd_data, rev_data = 9'h000;
    efs_ctl_pins_t ctl_level = 4'hA, ctl_out, ctl_oe;
    int fail_count = 0, checked = 0, irq_n = 0, n0, i;
    logic [8:0] fq [$];

    always #2 pclk = ~pclk;

    efs_fifo_service u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_dma_ack_n(port_dma_ack_n), .dma_tc(dma_tc), .io_read_n(io_read_n), .dma_wdata(dma_wdata),
        .dma_rdata(dma_rdata), .port_dma_request(port_dma_request), .port_irq_out(port_irq_out),
        .port_irq_oe(port_irq_oe), .peripheral_fault_n(fault_n), .peripheral_ack_n(ack_n),
        .ctl_level(ctl_level), .ctl_out(ctl_out), .ctl_oe(ctl_oe), .fwd_data(fwd_data), .fwd_valid(fwd_valid),
        .fwd_ready(fwd_ready), .rev_data(rev_data), .rev_valid(rev_valid), .rev_ready(rev_ready));

    efs_dma_model u_dma (.pclk(pclk), .to_dev(to_dev), .total(total), .done(dma_done),
        .port_dma_request(port_dma_request), .dma_rdata(dma_rdata), .port_dma_ack_n(port_dma_ack_n),
        .dma_tc(dma_tc), .io_read_n(io_read_n), .dma_wdata(dma_wdata));

    ////////////////////////////////////////////////////////////////////////////
    // Counts irq pulses and collects the forward stream
    always @(posedge pclk) begin
        irq_q <= port_irq_oe;
        if (port_irq_oe === 1'b1 && irq_q !== 1'b1) irq_n <= irq_n + 1;
        if (fwd_valid === 1'b1 && fwd_ready === 1'b1) fq.push_back(fwd_data);
    end

    task complete_run;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run

    task timeout;
        fail_count++;
        complete_run();
    endtask : timeout

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) timeout();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask : rdc

    task setc(input logic [31:0] v);
        wr(EFS_CTRL_OFS, (v & 32'hFFFFFFF8) | 32'h11);
        wr(EFS_CTRL_OFS, v);
    endtask : setc

    task wait_irq(input int n);
        int k;
        for (k = 0; k < 40 && irq_n <= n; k++) @(posedge pclk);
        chk(32'(irq_n > n), 32'h1);
        if (irq_n <= n) complete_run();
    endtask : wait_irq

    task wait_done(input logic [7:0] n);
        int k;
        for (k = 0; k < 3000 && dma_done !== n; k++) @(posedge pclk);
        if (k == 3000) timeout();
    endtask : wait_done

    task send_rev(input logic [8:0] d);
        int k;
        @(posedge pclk);
        rev_data <= d;
        rev_valid <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (rev_ready === 1'b1) break;
        end
        if (k == 50) timeout();
        rev_valid <= 1'b0;
        rev_data <= ~d;
    endtask : send_rev

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(EFS_CTRL_OFS, 32'h50);
        rdc(EFS_STAT_OFS, 32'h10);
        chk(ctl_oe, 4'h5);
        chk(ctl_out, 4'h0);
        // Forward programmed I/O, field 3: free-space trigger 12
        n0 = irq_n;
        setc(32'h302);
        wait_irq(n0);
        chk(ctl_oe, 4'hF);
        chk(ctl_out, 4'hA);
        wr(EFS_CMD_OFS, 32'h85);
        for (i = 1; i < 16; i++) begin
            wr(EFS_DATA_OFS, i);
            if (i == 3) rdc(EFS_STAT_OFS, 32'h84);
            if (i == 4) rdc(EFS_STAT_OFS, 32'h05);
        end
        wr(EFS_DATA_OFS, 32'h77);
        rdc(EFS_STAT_OFS, 32'h20);
        n0 = irq_n;
        fwd_ready <= 1'b1;
        wait_irq(n0);
        repeat (40) @(posedge pclk);
        chk(fq.size(), 16);
        chk(fq[0], 9'h185);
        for (i = 1; i < 16; i++) chk(fq[i], i);
        // Reverse programmed I/O with a run-length count of 3
        setc(32'hF0B);
        n0 = irq_n;
        send_rev(9'h103);
        send_rev(9'h0AB);
        wait_irq(n0);
        repeat (8) @(posedge pclk);
        rdc(EFS_STAT_OFS, 32'h84);
        wr(EFS_CTRL_OFS, 32'h00B);
        rdc(EFS_STAT_OFS, 32'h04);
        for (i = 0; i < 4; i++) rdc(EFS_DATA_OFS, 32'hAB);
        wr(EFS_CTRL_OFS, 32'hF0B);
        rdc(EFS_STAT_OFS, 32'h10);
        // Reverse DMA ended by terminal count, then re-armed
        total <= 8'h08;
        setc(32'h02B);
        n0 = irq_n;
        send_rev(9'h107);
        send_rev(9'h05A);
        wait_done(8'h08);
        wait_irq(n0);
        chk(port_dma_request, 1'b0);
        rdc(EFS_CTRL_OFS, 32'h3B);
        for (i = 0; i < 8; i++) chk(u_dma.rd_mem[i], 8'h5A);
        send_rev(9'h011);
        repeat (10) @(posedge pclk);
        chk(port_dma_request, 1'b0);
        total <= 8'h09;
        wr(EFS_CTRL_OFS, 32'h02B);
        wait_done(8'h09);
        chk(u_dma.rd_mem[8], 8'h11);
        // Forward DMA longer than one burst
        fq.delete();
        to_dev <= 1'b1;
        total <= 8'd49;
        setc(32'h022);
        wait_done(8'd49);
        repeat (20) @(posedge pclk);
        chk(fq.size(), 40);
        for (i = 0; i < 40; i++) chk(fq[i], i + 9);
        chk(port_dma_request, 1'b0);
        // Fault and acknowledge events
        setc(32'h090);
        n0 = irq_n;
        fault_n <= 1'b0;
        wait_irq(n0);
        ack_n <= 1'b0;
        repeat (6) @(posedge pclk);
        n0 = irq_n;
        ack_n <= 1'b1;
        wait_irq(n0);
        wr(EFS_CTRL_OFS, 32'h0D0);
        repeat (8) @(posedge pclk);
        n0 = irq_n;
        wr(EFS_CTRL_OFS, 32'h090);
        wait_irq(n0);
        complete_run();
    end
endmodule : efs_fifo_service_test
